// [rtl/eism_pkg.sv]
package eism_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int NUM_PINS = 8;
   localparam int NUM_KEYS = 16;
   localparam int NUM_WAKE = 8;
   localparam int REG_W    = 8;
   localparam int ADDR_W   = 8;
   localparam int SYNC_W   = NUM_PINS + NUM_KEYS + NUM_WAKE;

   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_SENSE_HIGH = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SENSE_LOW  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ENABLE     = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_KEY_UPPER  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_KEY_LOWER  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_WAKE_MASK  = 8'h18;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [REG_W-1:0] RST_SENSE_HIGH = 8'h00;
   localparam logic [REG_W-1:0] RST_SENSE_LOW  = 8'h00;
   localparam logic [REG_W-1:0] RST_ENABLE     = 8'h00;
   localparam logic [REG_W-1:0] RST_STATUS     = 8'h00;
   localparam logic [REG_W-1:0] RST_KEY_UPPER  = 8'hFF;
   localparam logic [REG_W-1:0] RST_KEY_LOWER  = 8'hBF;
   localparam logic [REG_W-1:0] RST_WAKE_MASK  = 8'hFF;

   // ----------------------------------------
   // field positions and encodings
   // ----------------------------------------
   localparam int PIN_SHARED_KEY_LOW  = 6;
   localparam int PIN_SHARED_KEY_HIGH = 7;
   localparam int SENSE_PINS_PER_REG  = 4;
   localparam int SENSE_BIT_B         = 1;
   localparam int SENSE_BIT_A         = 0;

   typedef enum logic [1:0] {
      SENSE_LOW_LEVEL = 2'h0,
      SENSE_FALLING   = 2'h1,
      SENSE_RISING    = 2'h2,
      SENSE_BOTH      = 2'h3
   } eism_sense_t;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [NUM_WAKE-1:0] wake_event_inputs_n;
      logic [NUM_KEYS-1:0] key_sense_inputs_n;
      logic [NUM_PINS-1:0] ext_request_pin_n;
   } eism_pins_t;

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic              pwrite;
      logic [31:0]       pwdata;
      logic [3:0]        pstrb;
   } eism_apb_req_t;

endpackage

// [rtl/eism_sync.sv]
module eism_sync #(
   parameter int                 WIDTH    = 1,
   parameter logic [WIDTH-1:0]   IDLE_VAL = '1
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // raw and filtered levels
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // ----------------------------------------
   // three stage capture, change taken once two late stages agree
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_r[i]    <= IDLE_VAL[i];
               s2_r[i]      <= IDLE_VAL[i];
               s3_r[i]      <= IDLE_VAL[i];
               level_out[i] <= IDLE_VAL[i];
            end else begin
               meta_r[i] <= async_in[i];
               s2_r[i]   <= meta_r[i];
               s3_r[i]   <= s2_r[i];
               if (s2_r[i] == s3_r[i]) begin
                  level_out[i] <= s3_r[i];
               end
            end
         end
      end
   endgenerate

endmodule

// [rtl/eism_top.sv]
// Functional notes
// RQ1 - sense 00: flag raised while pin input is low
// RQ2 - sense 01: flag raised on each high-to-low pin transition
// RQ3 - sense 10: flag raised on each low-to-high pin transition
// RQ4 - sense 11: flag raised on every pin transition
// RQ5 - two sense bits per pin, pins 7-4 high register, 3-0 low, B upper
// RQ6 - enable bit at pin index; request passes only while it is 1
// RQ7 - status flag set whenever the chosen sense condition occurs
// RQ8 - flag clears only after read as 1 then written 0; exception handling (RQ10, RQ11) also clears it without a read
// RQ9 - writing 1 to a status bit has no effect
// RQ10 - low-level mode: exception handling clears flag if input high
// RQ11 - edge modes: exception handling clears flag
// RQ12 - key and wake masks gate sixteen key and eight wake inputs
// RQ13 - key mask bit 0 lets key through, 1 blocks it
// RQ14 - upper key mask bits 7-0 map key inputs 15-8
// RQ15 - lower key mask bits 7-0 map key inputs 7-0
// RQ16 - lower key mask bit 6 also masks pin six; resets to 0
// RQ17 - flags set regardless of enable bits
// RQ18 - wake and keys 15-8 feed source 7; keys 7-0 feed source 6
// RQ19 - any upper key or wake mask bit 0 ignores pin seven
// RQ20 - wake mask bit per input, 0 enables, resets to 1
// RQ21 - request out is status flag AND enable bit
// RQ22 - inputs synchronised; edges found from consecutive samples
//
// Decided for this implementation: the address map and the APB register port.
module eism_top
   import eism_pkg::*;
(
   // clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire eism_pkg::eism_apb_req_t apb_req,
   output      logic [31:0]            prdata,
   output      logic                   pready,
   output      logic                   pslverr,
   // external inputs, active low
   input  wire eism_pkg::eism_pins_t    pins,
   // exception handling executed, one pulse per source
   input  wire logic [7:0]             exc_done,
   // requests to the priority logic
   output      logic [7:0]             irq_request
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0]  sense_select_high_r;
   logic [7:0]  sense_select_low_r;
   logic [7:0]  request_enable_r;
   logic [7:0]  request_status_r;
   logic [7:0]  request_status_nxt;
   logic [7:0]  key_mask_upper_r;
   logic [7:0]  key_mask_lower_r;
   logic [7:0]  wake_mask_r;
   logic [7:0]  read_armed_r;
   logic [7:0]  read_armed_nxt;

   // ----------------------------------------
   // bus state
   // ----------------------------------------
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        setup_ph;
   logic        access_done;
   logic        wr_done;
   logic        rd_done;
   logic        lane0;
   logic        addr_hit;
   logic [7:0]  rd_mux;
   logic [7:0]  wbyte;
   logic        wr_sense_high;
   logic        wr_sense_low;
   logic        wr_enable;
   logic        wr_status;
   logic        wr_key_upper;
   logic        wr_key_lower;
   logic        wr_wake_mask;

   // ----------------------------------------
   // input path
   // ----------------------------------------
   logic [SYNC_W-1:0] pins_sync;
   logic [7:0]        pin_lvl;
   logic [15:0]       key_lvl;
   logic [7:0]        wake_lvl;
   logic [15:0]       sense_all;
   logic [7:0]        src_lvl;
   logic [7:0]        src_prev_r;
   logic [7:0]        hit;
   logic [7:0]        exc_clr;
   logic              key_hi_on;
   logic              wake_on;
   logic              pin7_open;
   logic              key_lo_on;
   logic              pin6_open;
   logic [7:0]        irq_request_r;

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   // all pins idle high, so the filter starts at ones to avoid a false edge
   eism_sync #(
      .WIDTH    (SYNC_W),
      .IDLE_VAL ({SYNC_W{1'b1}})
   ) u_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .async_in  (pins),
      .level_out (pins_sync)
   ); // [RQ22]

   assign pin_lvl  = pins_sync[NUM_PINS-1:0];
   assign key_lvl  = pins_sync[NUM_PINS+NUM_KEYS-1:NUM_PINS];
   assign wake_lvl = pins_sync[SYNC_W-1:NUM_PINS+NUM_KEYS];

   // ----------------------------------------
   // key and wake gating
   // ----------------------------------------
   // a key or wake input pulls its source low only while its mask is 0
   assign key_hi_on = |(~key_lvl[15:8] & ~key_mask_upper_r); // [RQ13] [RQ14] [RQ12]
   assign wake_on   = |(~wake_lvl & ~wake_mask_r); // [RQ20] [RQ12]
   assign key_lo_on = |(~key_lvl[7:0] & ~key_mask_lower_r); // [RQ13] [RQ15]

   // pin seven only counts while every upper key and wake mask bit is 1
   assign pin7_open = (&key_mask_upper_r) & (&wake_mask_r); // [RQ19]
   // pin six shares the lower key mask bit six
   assign pin6_open = ~key_mask_lower_r[PIN_SHARED_KEY_LOW]; // [RQ16]

   // ----------------------------------------
   // source levels, high means idle
   // ----------------------------------------
   always_comb begin
      src_lvl = pin_lvl;
      src_lvl[PIN_SHARED_KEY_HIGH] = ~((~pin_lvl[PIN_SHARED_KEY_HIGH] & pin7_open)
                                       | key_hi_on | wake_on); // [RQ18]
      src_lvl[PIN_SHARED_KEY_LOW]  = ~((~pin_lvl[PIN_SHARED_KEY_LOW] & pin6_open)
                                       | key_lo_on); // [RQ18]
   end

   // previous sample of each source for edge finding
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_prev_r <= 8'hFF;
      end else begin
         src_prev_r <= src_lvl; // [RQ22]
      end
   end

   // ----------------------------------------
   // per-pin sense decode
   // ----------------------------------------
   assign sense_all = {sense_select_high_r, sense_select_low_r}; // [RQ5]

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         eism_sense_t mode;
         logic        fall;
         logic        rise;
         assign mode = eism_sense_t'({sense_all[2*g+SENSE_BIT_B], sense_all[2*g+SENSE_BIT_A]}); // [RQ5]
         assign fall = src_prev_r[g] & ~src_lvl[g];
         assign rise = ~src_prev_r[g] & src_lvl[g];
         always_comb begin
            case (mode)
               SENSE_LOW_LEVEL: begin
                  hit[g]     = ~src_lvl[g]; // [RQ1]
                  exc_clr[g] = exc_done[g] & src_lvl[g]; // [RQ10]
               end
               SENSE_FALLING: begin
                  hit[g]     = fall; // [RQ2]
                  exc_clr[g] = exc_done[g]; // [RQ11]
               end
               SENSE_RISING: begin
                  hit[g]     = rise; // [RQ3]
                  exc_clr[g] = exc_done[g]; // [RQ11]
               end
               default: begin
                  hit[g]     = fall | rise; // [RQ4]
                  exc_clr[g] = exc_done[g]; // [RQ11]
               end
            endcase
         end
      end
   endgenerate

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   // one wait-free answer: data is prepared in setup, pready rises in access
   assign setup_ph    = psel & ~penable;
   assign access_done = psel & penable & pready_r;
   assign wr_done     = access_done & apb_req.pwrite & ~pslverr_r;
   assign rd_done     = access_done & ~apb_req.pwrite & ~pslverr_r;
   assign lane0       = apb_req.pstrb[0];
   assign wbyte       = apb_req.pwdata[7:0];

   always_comb begin
      addr_hit = 1'b1;
      if (apb_req.paddr == OFS_SENSE_HIGH) begin
         rd_mux = sense_select_high_r;
      end else if (apb_req.paddr == OFS_SENSE_LOW) begin
         rd_mux = sense_select_low_r;
      end else if (apb_req.paddr == OFS_ENABLE) begin
         rd_mux = request_enable_r;
      end else if (apb_req.paddr == OFS_STATUS) begin
         rd_mux = request_status_r;
      end else if (apb_req.paddr == OFS_KEY_UPPER) begin
         rd_mux = key_mask_upper_r;
      end else if (apb_req.paddr == OFS_KEY_LOWER) begin
         rd_mux = key_mask_lower_r;
      end else if (apb_req.paddr == OFS_WAKE_MASK) begin
         rd_mux = wake_mask_r;
      end else begin
         rd_mux   = 8'h00;
         addr_hit = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else if (setup_ph) begin
         pready_r  <= 1'b1;
         pslverr_r <= ~addr_hit;
         prdata_r  <= {24'h00_0000, rd_mux};
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // write strobes
   // ----------------------------------------
   // lane 0 carries the whole register, so a write without it leaves every register alone
   assign wr_sense_high = wr_done & lane0 & (apb_req.paddr == OFS_SENSE_HIGH);
   assign wr_sense_low  = wr_done & lane0 & (apb_req.paddr == OFS_SENSE_LOW);
   assign wr_enable     = wr_done & lane0 & (apb_req.paddr == OFS_ENABLE);
   assign wr_status     = wr_done & lane0 & (apb_req.paddr == OFS_STATUS);
   assign wr_key_upper  = wr_done & lane0 & (apb_req.paddr == OFS_KEY_UPPER);
   assign wr_key_lower  = wr_done & lane0 & (apb_req.paddr == OFS_KEY_LOWER);
   assign wr_wake_mask  = wr_done & lane0 & (apb_req.paddr == OFS_WAKE_MASK);

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_select_high_r <= RST_SENSE_HIGH;
      end else if (wr_sense_high) begin
         sense_select_high_r <= wbyte; // [RQ5]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_select_low_r <= RST_SENSE_LOW;
      end else if (wr_sense_low) begin
         sense_select_low_r <= wbyte; // [RQ5]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         request_enable_r <= RST_ENABLE;
      end else if (wr_enable) begin
         request_enable_r <= wbyte; // [RQ6]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_mask_upper_r <= RST_KEY_UPPER;
      end else if (wr_key_upper) begin
         key_mask_upper_r <= wbyte; // [RQ14]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_mask_lower_r <= RST_KEY_LOWER;
      end else if (wr_key_lower) begin
         key_mask_lower_r <= wbyte; // [RQ15] [RQ16]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_mask_r <= RST_WAKE_MASK;
      end else if (wr_wake_mask) begin
         wake_mask_r <= wbyte; // [RQ20]
      end
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   // a new hit in the clearing cycle wins, so no event is lost
   always_comb begin
      request_status_nxt = request_status_r;
      read_armed_nxt     = read_armed_r;
      if (rd_done && apb_req.paddr == OFS_STATUS) begin
         read_armed_nxt = read_armed_r | prdata_r[7:0]; // [RQ8]
      end
      if (wr_status) begin
         // ones written are ignored; zeros clear only armed flags
         request_status_nxt = request_status_nxt & ~(read_armed_r & ~wbyte); // [RQ8] [RQ9]
      end
      request_status_nxt = request_status_nxt & ~exc_clr; // [RQ10] [RQ11]
      request_status_nxt = request_status_nxt | hit; // [RQ7] [RQ17]
      read_armed_nxt     = read_armed_nxt & request_status_nxt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         request_status_r <= RST_STATUS;
      end else begin
         request_status_r <= request_status_nxt; // [RQ7]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_armed_r <= 8'h00;
      end else begin
         read_armed_r <= read_armed_nxt; // [RQ8]
      end
   end

   // ----------------------------------------
   // request outputs
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_request_r <= 8'h00;
      end else begin
         irq_request_r <= request_status_nxt & request_enable_r; // [RQ21] [RQ6]
      end
   end

   assign irq_request = irq_request_r;
   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;

endmodule

// [bench/eism_checker.sv]
module eism_checker
   import eism_pkg::*;
(
   // clock and reset
   input wire logic                    pclk,
   input wire logic                    presetn,
   // apb
   input wire logic                    psel,
   input wire logic                    penable,
   input wire eism_pkg::eism_apb_req_t apb_req,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   // pins and requests
   input wire eism_pkg::eism_pins_t    pins,
   input wire logic [7:0]              exc_done,
   input wire logic [7:0]              irq_request
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------
   // quiet counter
   // ------------------
   // pins idle and no write for 15 cycles: nothing may raise a request
   logic [3:0] quiet_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_r <= 4'h0;
      end else if (pins != '1 || (psel && apb_req.pwrite)) begin
         quiet_r <= 4'h0;
      end else if (quiet_r != 4'hF) begin
         quiet_r <= quiet_r + 4'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------
   // properties
   // ------------------
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready longer than one cycle");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("error without ready or with data");
   property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_unm; psel && !penable && apb_req.paddr > OFS_WAKE_MASK |=> pslverr; endproperty
   a_unm: assert property (p_unm) else $error("unmapped access not refused");
   property p_en;
      logic [7:0] d;
      (psel && penable && pready && apb_req.pwrite && apb_req.pstrb[0] && apb_req.paddr == OFS_ENABLE,
       d = apb_req.pwdata[7:0]) |-> ##2 (irq_request & ~d) == 8'h00;
   endproperty
   a_en: assert property (p_en) else $error("request passed while disabled");
   property p_quiet; quiet_r == 4'hF |-> (irq_request & ~$past(irq_request)) == 8'h00; endproperty
   a_quiet: assert property (p_quiet) else $error("request rose with no cause");
   property p_rst; $rose(presetn) |-> irq_request == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("request set out of reset");
endmodule

bind eism_top eism_checker u_chk (.pclk, .presetn, .psel, .penable, .apb_req, .prdata, .pready,
   .pslverr, .pins, .exc_done, .irq_request);

// [bench/eism_pins_model.sv]
module eism_pins_model
   import eism_pkg::*;
(
   // clock
   input wire logic             pclk,
   // lines pulled low on request
   input wire logic [7:0]       pin_lo,
   input wire logic [15:0]      key_lo,
   input wire logic [7:0]       wake_lo,
   // lines toward the block
   output eism_pkg::eism_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // pulled-up lines: a released line returns high
   initial pins = '1;
   always @(posedge pclk) begin
      pins <= ~{wake_lo, key_lo, pin_lo};
   end
endmodule

// [bench/test_ext_irq_sense_mask.sv]
`define CHK(nm, e, g) begin \
   checks++; \
   if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end \
end
module test_ext_irq_sense_mask
   import eism_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          pclk, presetn, psel, penable, pready, pslverr, err;
   eism_apb_req_t apb_req;
   eism_pins_t    pins;
   logic [31:0]   prdata, rd;
   logic [7:0]    exc_done, irq_request, pin_lo, wake_lo;
   logic [15:0]   key_lo;
   int            n_mismatch = 0;
   int            checks = 0;
   int            cyc = 0;

   eism_top DUT (.pclk, .presetn, .psel, .penable, .apb_req, .prdata, .pready, .pslverr,
      .pins, .exc_done, .irq_request);
   eism_pins_model u_model (.pclk, .pin_lo, .key_lo, .wake_lo, .pins);

   // ------------------
   // bus tasks
   // ------------------
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      apb_req <= '{paddr: a, pwrite: w, pwdata: {24'h000000, d}, pstrb: 4'hF};
      @(posedge pclk);
      penable <= 1'b1;
      // the wait ends once pready is 1; only the bench ceiling ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
      apb(a, 1'b0, 8'h00);
      `CHK(nm, {24'h000000, e}, rd)
   endtask
   // edge or level plus five-edge input path, with margin
   task automatic settle;
      repeat (8) @(posedge pclk);
   endtask

   // ------------------
   // scenarios
   // ------------------
   task automatic s_reset;
      for (int i = 0; i < 7; i++) begin
         rd_chk(8'(i * 4), (i < 4) ? 8'h00 : (i == 5 ? 8'hBF : 8'hFF), "reset");
      end
      apb(8'h1C, 1'b0, 8'h00);
      `CHK("slverr", 1'b1, err)
   endtask
   task automatic s_modes;
      apb(OFS_SENSE_LOW, 1'b1, 8'hE4);
      apb(OFS_ENABLE, 1'b1, 8'h0F);
      pin_lo <= 8'h0F;
      settle();
      rd_chk(OFS_STATUS, 8'h0B, "fall");
      `CHK("irq", 8'h0B, irq_request)
      apb(OFS_STATUS, 1'b1, 8'h00);
      rd_chk(OFS_STATUS, 8'h01, "clr");
      pin_lo <= 8'h00;
      settle();
      rd_chk(OFS_STATUS, 8'h0D, "rise");
      exc_done <= 8'h0F;
      @(posedge pclk);
      exc_done <= 8'h00;
      rd_chk(OFS_STATUS, 8'h00, "exc");
   endtask
   task automatic s_clear;
      apb(OFS_ENABLE, 1'b1, 8'h00);
      pin_lo <= 8'h02;
      settle();
      pin_lo <= 8'h00;
      apb(OFS_STATUS, 1'b1, 8'h00);
      apb(OFS_STATUS, 1'b1, 8'hFF);
      rd_chk(OFS_STATUS, 8'h02, "noarm");
      `CHK("irq_off", 8'h00, irq_request)
      apb(OFS_STATUS, 1'b1, 8'h00);
      rd_chk(OFS_STATUS, 8'h00, "armed");
   endtask
   task automatic s_masks;
      apb(OFS_SENSE_HIGH, 1'b1, 8'h50);
      apb(OFS_ENABLE, 1'b1, 8'hC0);
      apb(OFS_KEY_LOWER, 1'b1, 8'hF7);
      apb(OFS_KEY_UPPER, 1'b1, 8'hFE);
      pin_lo <= 8'hC0;
      settle();
      rd_chk(OFS_STATUS, 8'h00, "pin_mask");
      key_lo <= 16'h0108;
      settle();
      rd_chk(OFS_STATUS, 8'hC0, "keys");
      `CHK("irq_keys", 8'hC0, irq_request)
      pin_lo <= 8'h00;
      key_lo <= 16'h0000;
      apb(OFS_STATUS, 1'b1, 8'h00);
      apb(OFS_KEY_UPPER, 1'b1, 8'hFF);
      apb(OFS_WAKE_MASK, 1'b1, 8'hFE);
      pin_lo <= 8'h80;
      settle();
      rd_chk(OFS_STATUS, 8'h00, "wake_gate");
      wake_lo <= 8'h01;
      settle();
      rd_chk(OFS_STATUS, 8'h80, "wake");
   endtask

   // ------------------
   // run control
   // ------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // a hang past this ceiling counts as a mismatch
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      apb_req = '0;
      exc_done = '0;
      pin_lo = '0;
      key_lo = '0;
      wake_lo = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      s_reset();
      s_modes();
      s_clear();
      s_masks();
      give_verdict();
   end
endmodule
